/* rtl/clock_gate_defines.svh */
// Register offsets, reset values and divider constants of the clock gating unit
`ifndef CLOCK_GATE_DEFINES_SVH
`define CLOCK_GATE_DEFINES_SVH

// Register indices; byte address is four times the index
`define CG_IDX_ENABLES    20'h40902
`define CG_IDX_STATUS     20'h40904
`define CG_IDX_RSVD_A     20'h40B00
`define CG_IDX_RSVD_B     20'h40B02

// Clock enable register
`define CG_ENABLES_RESET  16'h4003
`define CG_ENABLES_WMASK  16'hDFFB
`define CG_BIT_ESCAPE     4'hF
`define CG_BIT_DSP        4'hE
`define CG_BIT_RSVD_HI    4'hD
`define CG_BIT_RSVD_LO    4'h2
`define CG_BIT_SYS_IFACE  4'h1
`define CG_BIT_CPU        4'h0

// Clock tree factors and rates
`define CG_SYS_CLK_KHZ    3900
`define CG_CORE_CLK_KHZ   10000
`define CG_PRE_DIV        2'h2
`define CG_PLL_MULT       5'h14
`define CG_POST_DIV       2'h2

`endif

/* rtl/clock_gate_pkg.sv */
// Types shared by the clock gating unit
package clock_gate_pkg;
   typedef logic [15:0] gate_vec_t;

   typedef enum logic [3:0] {
      SEL_NONE    = 4'b0001,
      SEL_ENABLES = 4'b0010,
      SEL_STATUS  = 4'b0100,
      SEL_RSVD    = 4'b1000
   } reg_sel_t;
endpackage

/* rtl/clock_gating_unit.sv */
// Clock gating unit: per-block clock gates, clock tree dividers and AHB-Lite register slave
//
// Design decision made here: the AHB-Lite register port.
`include "clock_gate_defines.svh"

module clock_gating_unit
#(
   parameter int PRE_DIV = 2
) (
   input  wire logic                     CORE_CLK,
   input  wire logic                     RST_N,
   input  wire logic                     SYS_CLK_IN,
   input  wire logic                     HSEL,
   input  wire logic [31:0]              HADDR,
   input  wire logic [1:0]               HTRANS,
   input  wire logic                     HWRITE,
   input  wire logic [2:0]               HSIZE,
   input  wire logic [31:0]              HWDATA,
   input  wire logic                     HREADY,
   output logic      [31:0]              HRDATA,
   output logic                          HREADYOUT,
   output logic                          HRESP,
   output clock_gate_pkg::gate_vec_t     BLOCK_CLK,
   output logic                          PLL_REF_CLK,
   output logic      [4:0]               PLL_MULT,
   output logic      [1:0]               POST_DIV,
   output logic                          DSP_CLK_EN,
   output logic                          CPU_CLK_EN
);
   import clock_gate_pkg::*;

   localparam logic [31:0] ADDR_ENABLES = {10'h000, `CG_IDX_ENABLES, 2'b00};
   localparam logic [31:0] ADDR_STATUS  = {10'h000, `CG_IDX_STATUS, 2'b00};
   localparam logic [31:0] ADDR_RSVD_A  = {10'h000, `CG_IDX_RSVD_A, 2'b00};
   localparam logic [31:0] ADDR_RSVD_B  = {10'h000, `CG_IDX_RSVD_B, 2'b00};
   localparam logic [1:0]  PRE_LAST     = 2'(PRE_DIV - 1);

   logic        sys_level;
   logic        sys_prev_ff;
   logic        sys_edge;
   logic        sys_rise;
   gate_vec_t   clock_en_ff;
   gate_vec_t   nxt_clock_en;
   gate_vec_t   gate_latch_ff;
   gate_vec_t   nxt_gate_latch;
   gate_vec_t   nxt_block_clk;
   logic [1:0]  pre_cnt_ff;
   logic [1:0]  nxt_pre_cnt;
   logic        nxt_pll_ref;
   logic        wr_pend_ff;
   logic        nxt_wr_pend;
   reg_sel_t    wsel_ff;
   reg_sel_t    nxt_wsel;
   reg_sel_t    sel;
   logic        addr_valid;
   logic        en_write;
   logic [31:0] nxt_hrdata;

   // System clock arrives asynchronously to the core clock
   pin_sync u_sys_sync (
      .CORE_CLK  (CORE_CLK),
      .RST_N     (RST_N),
      .pin_in    (SYS_CLK_IN),
      .level_out (sys_level)
   );

   assign sys_edge = sys_level ^ sys_prev_ff;
   assign sys_rise = sys_level & ~sys_prev_ff;

   // Bus decode
   always_comb begin
      addr_valid = HSEL & HTRANS[1] & HREADY;
      unique case (HADDR)
         ADDR_ENABLES: sel = SEL_ENABLES;
         ADDR_STATUS:  sel = SEL_STATUS;
         ADDR_RSVD_A:  sel = SEL_RSVD;
         ADDR_RSVD_B:  sel = SEL_RSVD;
         default:      sel = SEL_NONE;
      endcase
      nxt_wr_pend = addr_valid & HWRITE;
      nxt_wsel    = addr_valid ? sel : SEL_NONE;
   end

   // Register write lands in the data phase; reserved bits never stick
   always_comb begin
      en_write     = wr_pend_ff & (wsel_ff == SEL_ENABLES);
      nxt_clock_en = en_write ? (HWDATA[15:0] & `CG_ENABLES_WMASK) : clock_en_ff;
   end

   // Read data is prepared in the address phase so the slave never waits;
   // a write still in its data phase is forwarded so back-to-back reads see it
   always_comb begin
      nxt_hrdata = HRDATA;
      if (addr_valid && !HWRITE) begin
         unique case (sel)
            SEL_ENABLES: nxt_hrdata = {16'h0000, nxt_clock_en};
            SEL_STATUS:  nxt_hrdata = {16'h0000, gate_latch_ff};
            SEL_RSVD:    nxt_hrdata = 32'h0000_0000;
            SEL_NONE:    nxt_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         wr_pend_ff  <= 1'b0;
         wsel_ff     <= SEL_NONE;
         clock_en_ff <= `CG_ENABLES_RESET;
         HRDATA      <= 32'h0000_0000;
         HREADYOUT   <= 1'b1;
         HRESP       <= 1'b0;
      end else begin
         wr_pend_ff  <= nxt_wr_pend;
         wsel_ff     <= nxt_wsel;
         clock_en_ff <= nxt_clock_en;
         HRDATA      <= nxt_hrdata;
         HREADYOUT   <= 1'b1;
         HRESP       <= 1'b0;
      end
   end

   // Gate latch is open only in the low phase, so a high phase is never cut short
   always_comb begin
      nxt_gate_latch = sys_level ? gate_latch_ff : clock_en_ff;
   end

   // Each gate passes the buffered system clock only while its latched enable is set
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_gate
         assign nxt_block_clk[gi] = sys_level & gate_latch_ff[gi];
      end
   endgenerate

   // Pre-divider toggles after PRE_DIV system clock edges, dividing the rate by PRE_DIV
   always_comb begin
      nxt_pre_cnt = pre_cnt_ff;
      nxt_pll_ref = PLL_REF_CLK;
      if (sys_edge) begin
         if (pre_cnt_ff == PRE_LAST) begin
            nxt_pre_cnt = 2'h0;
            nxt_pll_ref = ~PLL_REF_CLK;
         end else begin
            nxt_pre_cnt = pre_cnt_ff + 2'h1;
         end
      end
   end

   // The PLL and its post-divider are analog/fast macros; this block feeds the
   // reference, sets the factors and gates the two core clocks
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sys_prev_ff   <= 1'b0;
         gate_latch_ff <= `CG_ENABLES_RESET;
         BLOCK_CLK     <= 16'h0000;
         pre_cnt_ff    <= 2'h0;
         PLL_REF_CLK   <= 1'b0;
         PLL_MULT      <= `CG_PLL_MULT;
         POST_DIV      <= `CG_POST_DIV;
         DSP_CLK_EN    <= 1'b0;
         CPU_CLK_EN    <= 1'b0;
      end else begin
         sys_prev_ff   <= sys_level;
         gate_latch_ff <= nxt_gate_latch;
         BLOCK_CLK     <= nxt_block_clk;
         pre_cnt_ff    <= nxt_pre_cnt;
         PLL_REF_CLK   <= nxt_pll_ref;
         PLL_MULT      <= `CG_PLL_MULT;
         POST_DIV      <= `CG_POST_DIV;
         DSP_CLK_EN    <= gate_latch_ff[`CG_BIT_DSP];
         CPU_CLK_EN    <= gate_latch_ff[`CG_BIT_CPU];
      end
   end

   // Checks
   logic first_ff;
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         first_ff <= 1'b1;
      end else begin
         first_ff <= 1'b0;
      end
   end

   AST_RESET_VALUE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      first_ff |-> (clock_en_ff == 16'h4003 && gate_latch_ff == 16'h4003))
      else $error("Enable register left reset with wrong value");
   AST_GATE_PASSES: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (gate_latch_ff[1] && sys_level) |=> BLOCK_CLK[1])
      else $error("Enabled gate did not pass system clock high");
   AST_GATE_STOPS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (!gate_latch_ff[5] && !sys_level) ##1 !gate_latch_ff[5] |-> !BLOCK_CLK[5] ##1 !BLOCK_CLK[5])
      else $error("Disabled gate clock not held low");
   AST_NO_RUNT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(BLOCK_CLK[5]) |-> $past(sys_rise))
      else $error("Gated clock rose away from a system clock rising edge");
   AST_FOLLOW_SYS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (BLOCK_CLK & ~{16{$past(sys_level)}}) == 16'h0000)
      else $error("Gated clock high while system clock low");
   AST_LATCH_CLOSED: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      sys_level |=> $stable(gate_latch_ff))
      else $error("Gate latch changed in high phase");
   AST_LATCH_OPEN: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !sys_level |=> gate_latch_ff == $past(clock_en_ff))
      else $error("Gate latch not transparent in low phase");
   AST_PREDIV: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $changed(PLL_REF_CLK) |-> $past(sys_edge) && $past(pre_cnt_ff) == PRE_LAST)
      else $error("Pre-divider toggled off its count");
   AST_FACTORS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !first_ff |-> PLL_MULT == 5'h14 && POST_DIV == 2'h2)
      else $error("PLL factors wrong");
   AST_RESERVED: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      !clock_en_ff[13] && !clock_en_ff[2])
      else $error("Reserved enable bit set");

   COV_WRITE_EN: cover property (@(posedge CORE_CLK) disable iff (!RST_N) en_write);
   COV_GATE_ON: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(BLOCK_CLK[5]));
   COV_GATE_OFF: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $fell(gate_latch_ff[14]));
   COV_REF_RISE: cover property (@(posedge CORE_CLK) disable iff (!RST_N) $rose(PLL_REF_CLK));
endmodule

/* rtl/pin_sync.sv */
// Four-stage synchroniser for a pin; no agreement filter, as a system clock phase may hold one core sample
module pin_sync (
   input  wire logic CORE_CLK,
   input  wire logic RST_N,
   input  wire logic pin_in,
   output logic      level_out
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;
   logic nxt_level;

   always_comb begin
      nxt_level = s3_ff;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_ff     <= 1'b0;
         s2_ff     <= 1'b0;
         s3_ff     <= 1'b0;
         level_out <= 1'b0;
      end else begin
         s1_ff     <= pin_in;
         s2_ff     <= s1_ff;
         s3_ff     <= s2_ff;
         level_out <= nxt_level;
      end
   end
endmodule

/* testbench/clock_gating_pll_divider_tb.sv */
// Self-checking bench of the clock gating unit
`include "clock_gate_defines.svh"
module clock_gating_pll_divider_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import clock_gate_pkg::*;
   localparam logic [31:0] A_EN = 32'({`CG_IDX_ENABLES, 2'b00});
   localparam logic [31:0] A_ST = 32'({`CG_IDX_STATUS, 2'b00});
   localparam logic [31:0] A_RA = 32'({`CG_IDX_RSVD_A, 2'b00});
   localparam logic [31:0] A_RB = 32'({`CG_IDX_RSVD_B, 2'b00});
   logic CORE_CLK, RST_N, SYS_CLK_IN, HSEL, HWRITE, HREADYOUT, HRESP, PLL_REF_CLK;
   logic DSP_CLK_EN, CPU_CLK_EN, clr, rd_dp;
   logic [31:0] HADDR, HWDATA, HRDATA, d;
   logic [1:0] HTRANS, POST_DIV;
   logic [2:0] HSIZE;
   logic [4:0] PLL_MULT;
   gate_vec_t BLOCK_CLK;
   int rises [16];
   int ref_rises, sys_rises, seed, cyc, bad_count, compares;
   logic [31:0] exp_q [$];

   clock_gating_unit #(.PRE_DIV(2)) u_dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .SYS_CLK_IN(SYS_CLK_IN),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
      .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .BLOCK_CLK(BLOCK_CLK),
      .PLL_REF_CLK(PLL_REF_CLK), .PLL_MULT(PLL_MULT), .POST_DIV(POST_DIV), .DSP_CLK_EN(DSP_CLK_EN),
      .CPU_CLK_EN(CPU_CLK_EN));
   sys_clk_model u_far (.SYS_CLK(SYS_CLK_IN), .BLOCK_CLK(BLOCK_CLK), .PLL_REF_CLK(PLL_REF_CLK),
      .clr(clr), .rises(rises), .ref_rises(ref_rises), .sys_rises(sys_rises));

   initial CORE_CLK = 1'b0;
   always #50 CORE_CLK = ~CORE_CLK;

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Single transfer: address phase held until ready, then data phase held until ready
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      HSEL <= 1'b1; HTRANS <= 2'h2; HADDR <= a; HWRITE <= w;
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
      HTRANS <= 2'h0; HWDATA <= wd; rd_dp <= !w;
      @(posedge CORE_CLK);
      while (HREADYOUT !== 1'b1) @(posedge CORE_CLK);
      rd_dp <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask

   function automatic logic [31:0] near(input int k);
      return {31'h0, k >= -1 && k <= 1};
   endfunction

   // Let the enables settle, then count gated edges over a fresh window
   task automatic gates(input logic [15:0] v);
      logic [15:0] e;
      logic [15:0] seen;
      e = v & `CG_ENABLES_WMASK;
      repeat (10) @(posedge CORE_CLK);
      clr <= 1'b1;
      @(posedge CORE_CLK);
      clr <= 1'b0;
      repeat (40) @(posedge CORE_CLK);
      for (int i = 0; i < 16; i++) seen[i] = rises[i] != 0;
      check("gate_run", {16'h0, seen}, {16'h0, e});
      check("core_en", {30'h0, DSP_CLK_EN, CPU_CLK_EN}, {30'h0, e[14], e[0]});
      // Each running gate must carry every system clock period, not a filtered subset
      for (int i = 0; i < 16; i++) if (e[i]) check("gate_rate", near(rises[i] - sys_rises), 32'h1);
      check("pre_div", near(sys_rises / 2 - ref_rises), 32'h1);
      rd(A_ST, {16'h0, e});
      $display("gate test %h done", v);
   endtask

   // Read data is compared at the edge that ends its data phase
   always @(posedge CORE_CLK) begin
      if (rd_dp && HREADYOUT) begin
         check("hrdata", HRDATA, exp_q.pop_front());
         check("hresp_rd", {31'h0, HRESP}, 32'h0);
      end
   end

   // A hang costs a mismatch and ends the run
   always @(posedge CORE_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         summarize;
      end
   end

   initial begin
      seed = 20415;
      RST_N = 1'b0; HSEL = 1'b0; HADDR = 32'h0; HTRANS = 2'h0; HWRITE = 1'b0;
      HSIZE = 3'h2; HWDATA = 32'h0; clr = 1'b0; rd_dp = 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      @(posedge CORE_CLK);
      check("pll_mult", {27'h0, PLL_MULT}, 32'd20);
      check("post_div", {30'h0, POST_DIV}, 32'd2);
      check("hresp", {31'h0, HRESP}, 32'h0);
      check("hready", {31'h0, HREADYOUT}, 32'h1);
      rd(A_EN, 32'h00004003);
      gates(16'h4003);
      xfer(1'b1, A_RA, 32'h0000FFFF);
      rd(A_RA, 32'h0);
      rd(A_RB, 32'h0);
      rd(32'h00102000, 32'h0);
      $display("reserved test done");
      xfer(1'b1, A_EN, 32'hFFFFFFFF);
      rd(A_EN, {16'h0, `CG_ENABLES_WMASK});
      gates(16'hFFFF);
      xfer(1'b1, A_EN, 32'h0);
      rd(A_EN, 32'h0);
      gates(16'h0000);
      repeat (3) begin
         d = $random(seed);
         xfer(1'b1, A_EN, d);
         rd(A_EN, {16'h0, d[15:0] & `CG_ENABLES_WMASK});
         gates(d[15:0]);
      end
      // A second reset mid-run must restore the default enables
      RST_N <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      @(posedge CORE_CLK);
      rd(A_EN, 32'h00004003);
      gates(16'h4003);
      summarize;
   end
endmodule

/* testbench/sys_clk_model.sv */
// System clock source and gated clock consumers facing the clock gating unit
module sys_clk_model (
   output logic             SYS_CLK,
   input  wire logic [15:0] BLOCK_CLK,
   input  wire logic        PLL_REF_CLK,
   input  wire logic        clr,
   output int               rises [16],
   output int               ref_rises,
   output int               sys_rises
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] prev;

   // Free-running square wave, unrelated in phase to the core clock
   initial SYS_CLK = 1'b0;
   always #128.2 SYS_CLK = ~SYS_CLK;

   // Each consumer counts the rising edges its gate lets through
   always @(BLOCK_CLK, clr) begin
      for (int i = 0; i < 16; i++) begin
         if (clr) rises[i] = 0;
         else if (BLOCK_CLK[i] && !prev[i]) rises[i] = rises[i] + 1;
      end
      prev = BLOCK_CLK;
   end

   always @(posedge PLL_REF_CLK or posedge clr) begin
      ref_rises <= clr ? 0 : ref_rises + 1;
   end

   // Reference count of system clock periods, taken at the source
   always @(posedge SYS_CLK or posedge clr) begin
      sys_rises <= clr ? 0 : sys_rises + 1;
   end
endmodule
